/* File: verilog/pqf_pkg.sv */
// Constants, register map and state types of the packet queue formatter.
// Assumes a 32-bit classic Wishbone slave port and 16-bit queue words.
package pqf_pkg;

   localparam int          AW           = 11;          // 2048 x 16 bit = 4 KB per queue
   localparam int          PW           = 12;          // pointer with wrap bit
   localparam logic [11:0] QDEPTH       = 12'h800;
   localparam logic [11:0] HDR_WORDS    = 12'h002;

   // Register byte offsets
   localparam logic [7:0]  ADR_CTRL     = 8'h00;
   localparam logic [7:0]  ADR_TX_DATA  = 8'h04;
   localparam logic [7:0]  ADR_TX_FREE  = 8'h08;
   localparam logic [7:0]  ADR_TX_STAT  = 8'h0C;
   localparam logic [7:0]  ADR_RX_STAT  = 8'h10;
   localparam logic [7:0]  ADR_RX_CNT   = 8'h14;
   localparam logic [7:0]  ADR_RX_DATA  = 8'h18;
   localparam logic [7:0]  ADR_RX_REL   = 8'h1C;

   localparam logic [1:0]  CTRL_RESET   = 2'h0;
   localparam int          CTRL_PASS_BAD = 0;
   localparam int          CTRL_STRIP   = 1;

   // Transmit control word and status fields
   localparam int          TXC_IRQ      = 15;
   localparam int          TAG_W        = 6;
   localparam int          TXS_BUSY     = 8;

   // Receive status word fields
   localparam int          RXS_VALID    = 15;
   localparam int          RXS_BCAST    = 7;
   localparam int          RXS_MCAST    = 6;
   localparam int          RXS_UCAST    = 5;
   localparam int          RXS_TYPE     = 3;
   localparam int          RXS_LONG     = 2;
   localparam int          RXS_RUNT     = 1;
   localparam int          RXS_CRC      = 0;

   localparam int          LEN_W        = 11;
   localparam logic [11:0] RX_MAX_LEN   = 12'h77C;     // 1916
   localparam logic [11:0] LONG_LEN     = 12'h5EE;     // 1518
   localparam logic [15:0] TYPE_MIN     = 16'h05DC;    // 1500
   localparam logic [11:0] CRC_BYTES    = 12'h004;
   localparam logic [11:0] DA_BYTES     = 12'h006;
   localparam logic [11:0] TYPE_HI_IDX  = 12'h00C;
   localparam logic [11:0] TYPE_LO_IDX  = 12'h00D;

   typedef enum logic [3:0] {
      T_IDLE   = 4'h0,
      T_CTRL_W = 4'h1,
      T_CTRL_L = 4'h2,
      T_CNT_W  = 4'h3,
      T_CNT_L  = 4'h4,
      T_DAT_W  = 4'h5,
      T_DAT_L  = 4'h6,
      T_LO     = 4'h7,
      T_HI     = 4'h8,
      T_DONE   = 4'h9
   } pqf_tx_e;

   typedef enum logic [1:0] {
      R_RECV = 2'h0,
      R_HDR0 = 2'h1,
      R_HDR1 = 2'h2
   } pqf_rx_e;

   typedef enum logic [2:0] {
      L_IDLE = 3'h0,
      L_W0   = 3'h1,
      L_L0   = 3'h2,
      L_W1   = 3'h3,
      L_L1   = 3'h4
   } pqf_ld_e;

endpackage

/* File: verilog/pqf_qmem.sv */
// Queue packet memory: one write port, one read port, registered read data.
// Assumes a single clock; a read of the word written in the same cycle gives the old word.
`timescale 1ns/1ps
module pqf_qmem #(
   parameter int DW = 16,
   parameter int AW = 11
) (
   input  wire logic          clk_i,
   input  wire logic          ce_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [DW-1:0] rdata_o
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk_i) begin
      if (ce_i && we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         rdata_o <= mem[raddr_i];
      end
   end

endmodule

/* File: verilog/pqf_top.sv */
// Packet queue formatter: transmit and receive queues between host and MAC.
// Assumes a classic Wishbone master, a byte-wide MAC stream on each side, one clock.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

// Function
// R01 - TX entry: control word, count, data
// R02 - Separate 4 KB transmit and receive queues
// R03 - Control bit 15 raises done interrupt
// R04 - Six-bit tag labels transmit status
// R05 - Host writes nonzero correct byte count
// R06 - Entry occupies only words frame needs
// R07 - All frame bytes from host, unmodified
// R08 - Length/type passed through as data
// R09 - RX entry: status, count, data, 1916 max
// R10 - CRC kept unless stripping enabled
// R11 - Status shows frame at queue head
// R12 - Valid bit only for complete frame
// R13 - Bit 7 marks broadcast destination
// R14 - Bit 6 marks multicast, incl broadcast
// R15 - Bit 5 marks unicast destination
// R16 - Bit 3 set when type exceeds 1500
// R17 - Bit 2 over 1518, untruncated, pass-bad
// R18 - Bit 1 runt, delivered only pass-bad
// R19 - Bit 0 CRC error, only pass-bad
// R20 - Byte count in bits 10:0
// R21 - Reserved bits zero
module pqf_top
   import pqf_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic      [7:0]  tx_data_o,
   output logic             tx_valid_o,
   output logic             tx_last_o,
   input  wire logic        tx_ready_i,
   output logic             tx_irq_o,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_valid_i,
   input  wire logic        rx_last_i,
   input  wire logic        rx_crc_err_i,
   input  wire logic        rx_runt_i,
   output logic             rx_ready_o
);
   import pqf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: request stage then ack, so every answer comes two edges later
   logic        acc;
   logic        stage_reg;
   logic        wr_go;
   logic        rd_go;
   logic [1:0]  ctrl_reg;
   logic [15:0] tx_status_reg;
   logic [15:0] rx_status_reg;
   logic [LEN_W-1:0] rx_len_reg;

   assign acc   = cyc_i && stb_i && !ack_o && !stage_reg;
   assign wr_go = stage_reg && we_i;
   assign rd_go = stage_reg && !we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage_reg <= 1'b0;
         ack_o     <= 1'b0;
      end else if (ce_i) begin
         stage_reg <= acc;
         ack_o     <= stage_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= CTRL_RESET;
      end else if (ce_i && wr_go && adr_i == ADR_CTRL && sel_i[0]) begin
         ctrl_reg <= dat_i[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit queue, host side
   logic [PW-1:0]    tx_wp;
   logic [PW-1:0]    tx_commit;
   logic [PW-1:0]    tx_rel;
   logic [PW-1:0]    te_ptr;
   logic [1:0]       tw_phase;
   logic [LEN_W-1:0] tw_left;
   logic [PW-1:0]    tx_free;
   logic             tx_wr;
   logic [15:0]      tx_rdata;

   assign tx_free = QDEPTH - (tx_wp - tx_rel);
   // Writes into a full queue are dropped; software checks the free count first
   assign tx_wr   = ce_i && wr_go && adr_i == ADR_TX_DATA && (&sel_i[1:0]) && tx_free != '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_wp     <= '0;
         tx_commit <= '0;
         tw_phase  <= 2'h0;
         tw_left   <= '0;
      end else if (tx_wr) begin
         tx_wp <= tx_wp + 1'b1;
         case (tw_phase)
            2'h0: tw_phase <= 2'h1;                                   // [R01]
            2'h1: begin
               // Only ceil(count/2) data words are claimed [R06] [R05]
               tw_left <= LEN_W'((dat_i[LEN_W-1:0] + 12'h001) >> 1);
               if (dat_i[LEN_W-1:0] == '0) begin
                  tw_phase  <= 2'h0;
                  tx_commit <= tx_wp + 1'b1;
               end else begin
                  tw_phase <= 2'h2;
               end
            end
            default: begin
               tw_left <= tw_left - 1'b1;
               if (tw_left == LEN_W'(1)) begin
                  tw_phase  <= 2'h0;
                  tx_commit <= tx_wp + 1'b1;
               end
            end
         endcase
      end
   end

   pqf_qmem #(.DW(16), .AW(AW)) u_transmit_queue (                    // [R02]
      .clk_i   (clk_i),
      .ce_i    (ce_i),
      .we_i    (tx_wr),
      .waddr_i (tx_wp[AW-1:0]),
      .wdata_i (dat_i[15:0]),
      .raddr_i (te_ptr[AW-1:0]),
      .rdata_o (tx_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transmit engine: bytes leave exactly as written, no address or type handling
   pqf_tx_e          tx_state;
   logic [15:0]      tx_ctrl;
   logic [LEN_W-1:0] tx_rem;
   logic [7:0]       tx_hi;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_state      <= T_IDLE;
         te_ptr        <= '0;
         tx_rel        <= '0;
         tx_ctrl       <= '0;
         tx_rem        <= '0;
         tx_hi         <= '0;
         tx_data_o     <= '0;
         tx_valid_o    <= 1'b0;
         tx_last_o     <= 1'b0;
         tx_irq_o      <= 1'b0;
         tx_status_reg <= '0;
      end else if (ce_i) begin
         tx_irq_o <= 1'b0;
         case (tx_state)
            T_IDLE: begin
               if (tx_commit != tx_rel) begin
                  te_ptr   <= tx_rel;
                  tx_state <= T_CTRL_W;
               end
            end
            T_CTRL_W: tx_state <= T_CTRL_L;
            T_CTRL_L: begin
               tx_ctrl       <= tx_rdata;
               tx_status_reg <= 16'(tx_rdata[TAG_W-1:0]) | (16'h0001 << TXS_BUSY); // [R04]
               te_ptr        <= te_ptr + 1'b1;
               tx_state      <= T_CNT_W;
            end
            T_CNT_W: tx_state <= T_CNT_L;
            T_CNT_L: begin
               tx_rem   <= tx_rdata[LEN_W-1:0];
               te_ptr   <= te_ptr + 1'b1;
               tx_state <= (tx_rdata[LEN_W-1:0] == '0) ? T_DONE : T_DAT_W;
            end
            T_DAT_W: tx_state <= T_DAT_L;
            T_DAT_L: begin
               // First byte in the low half of each word [R07] [R08]
               tx_data_o  <= tx_rdata[7:0];
               tx_hi      <= tx_rdata[15:8];
               tx_valid_o <= 1'b1;
               tx_last_o  <= (tx_rem == LEN_W'(1));
               te_ptr     <= te_ptr + 1'b1;
               tx_state   <= T_LO;
            end
            T_LO: begin
               if (tx_ready_i) begin
                  tx_rem <= tx_rem - 1'b1;
                  if (tx_rem == LEN_W'(1)) begin
                     tx_valid_o <= 1'b0;
                     tx_last_o  <= 1'b0;
                     tx_state   <= T_DONE;
                  end else begin
                     tx_data_o <= tx_hi;
                     tx_last_o <= (tx_rem == LEN_W'(2));
                     tx_state  <= T_HI;
                  end
               end
            end
            T_HI: begin
               if (tx_ready_i) begin
                  tx_rem     <= tx_rem - 1'b1;
                  tx_valid_o <= 1'b0;
                  tx_last_o  <= 1'b0;
                  tx_state   <= (tx_rem == LEN_W'(1)) ? T_DONE : T_DAT_W;
               end
            end
            T_DONE: begin
               tx_rel                  <= te_ptr;
               tx_irq_o                <= tx_ctrl[TXC_IRQ];            // [R03]
               tx_status_reg[TXS_BUSY] <= 1'b0;
               tx_state                <= T_IDLE;
            end
            default: tx_state <= T_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive engine: data from word 2 on, header written only at frame end
   pqf_rx_e        rx_state;
   logic [PW-1:0]  rx_rb;
   logic [PW-1:0]  rx_rw;
   logic [PW-1:0]  rx_head;
   logic [11:0]    rx_cnt;
   logic [7:0]     rx_low;
   logic [7:0]     rx_thi;
   logic           rx_bc;
   logic           rx_mc;
   logic           rx_type;
   logic           rx_ovf;
   logic [15:0]    rx_stat_w;
   logic [11:0]    rx_len_w;
   logic [12:0]    rx_frames;
   logic           rx_beat;
   logic [11:0]    len_raw;
   logic [11:0]    len_out;
   logic           rx_long;
   logic           rx_bad;
   logic           rx_space;
   logic           rx_we;
   logic [AW-1:0]  rx_waddr;
   logic [15:0]    rx_wdata;
   logic           rel_go;
   logic [PW-1:0]  rb_new;
   logic           bc_byte;

   assign rx_beat  = rx_valid_i && rx_ready_o && rx_state == R_RECV;
   assign len_raw  = rx_cnt + 12'h001;
   // With stripping set, CRC bytes stay in memory but fall outside the reported count [R10]
   assign len_out  = (ctrl_reg[CTRL_STRIP] && len_raw >= CRC_BYTES) ? len_raw - CRC_BYTES
                     : len_raw;
   assign rx_long  = len_raw > LONG_LEN;                               // [R17]
   assign rx_bad   = rx_crc_err_i || rx_runt_i || rx_long;              // [R18] [R19]
   assign rx_space = (rx_rw - rx_head) < QDEPTH;
   assign rb_new   = rx_rb + HDR_WORDS + PW'((rx_len_w + 12'h001) >> 1);
   assign bc_byte  = (rx_data_i == 8'hFF);

   always_comb begin
      rx_we    = 1'b0;
      rx_waddr = rx_rw[AW-1:0];
      rx_wdata = {rx_data_i, rx_low};
      case (rx_state)
         R_RECV: begin
            rx_we    = ce_i && rx_beat && (rx_cnt[0] || rx_last_i) && rx_space && !rx_ovf
                       && len_raw <= RX_MAX_LEN;
            rx_wdata = rx_cnt[0] ? {rx_data_i, rx_low} : {8'h00, rx_data_i};
         end
         R_HDR0: begin                                                  // [R09]
            rx_we    = ce_i;
            rx_waddr = rx_rb[AW-1:0];
            rx_wdata = rx_stat_w;
         end
         R_HDR1: begin
            rx_we    = ce_i;
            rx_waddr = AW'(rx_rb[AW-1:0] + 1'b1);
            rx_wdata = {5'h00, rx_len_w[LEN_W-1:0]};                    // [R20] [R21]
         end
         default: rx_we = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_state   <= R_RECV;
         rx_ready_o <= 1'b0;
         rx_rb      <= '0;
         rx_rw      <= HDR_WORDS;
         rx_cnt     <= '0;
         rx_low     <= '0;
         rx_thi     <= '0;
         rx_bc      <= 1'b0;
         rx_mc      <= 1'b0;
         rx_type    <= 1'b0;
         rx_ovf     <= 1'b0;
         rx_stat_w  <= '0;
         rx_len_w   <= '0;
      end else if (ce_i) begin
         case (rx_state)
            R_RECV: begin
               rx_ready_o <= 1'b1;
               if (rx_beat) begin
                  rx_cnt <= len_raw;
                  rx_low <= rx_data_i;
                  if (rx_cnt == '0) begin
                     rx_mc <= rx_data_i[0];                             // [R14] [R15]
                     rx_bc <= bc_byte;
                  end else if (rx_cnt < DA_BYTES) begin
                     rx_bc <= rx_bc && bc_byte;                         // [R13]
                  end
                  if (rx_cnt == TYPE_HI_IDX) begin
                     rx_thi <= rx_data_i;
                  end
                  if (rx_cnt == TYPE_LO_IDX) begin
                     rx_type <= {rx_thi, rx_data_i} > TYPE_MIN;         // [R16]
                  end
                  if (rx_we == 1'b0 && (rx_cnt[0] || rx_last_i)) begin
                     rx_ovf <= 1'b1;
                  end else if (rx_we) begin
                     rx_rw <= rx_rw + 1'b1;
                  end
                  if (rx_last_i) begin
                     rx_cnt <= '0;
                     rx_ovf <= 1'b0;
                     rx_bc  <= 1'b0;
                     rx_mc  <= 1'b0;
                     rx_type <= 1'b0;
                     // Bad frames kept only with pass-bad set [R17] [R18] [R19]
                     if ((rx_bad && !ctrl_reg[CTRL_PASS_BAD]) || rx_ovf || !rx_we) begin
                        rx_rw <= rx_rb + HDR_WORDS;
                     end else begin
                        rx_ready_o <= 1'b0;
                        rx_state   <= R_HDR0;
                        rx_len_w   <= len_out;
                        rx_stat_w  <= (16'h0001 << RXS_VALID)           // [R12]
                           | (16'(rx_bc && rx_cnt >= DA_BYTES) << RXS_BCAST)
                           | (16'(rx_mc) << RXS_MCAST)
                           | (16'(!rx_mc) << RXS_UCAST)
                           | (16'(rx_type) << RXS_TYPE)
                           | (16'(rx_long) << RXS_LONG)
                           | (16'(rx_runt_i) << RXS_RUNT)
                           | (16'(rx_crc_err_i) << RXS_CRC);
                     end
                  end
               end
            end
            R_HDR0: rx_state <= R_HDR1;
            R_HDR1: begin
               rx_rb    <= rb_new;
               rx_rw    <= rb_new + HDR_WORDS;
               rx_state <= R_RECV;
            end
            default: rx_state <= R_RECV;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive queue, host side: head frame's header loaded into the status registers
   pqf_ld_e       ld_state;
   logic          presented;
   logic [PW-1:0] ld_ptr;
   logic [PW-1:0] hp;
   logic [AW-1:0] rx_raddr;
   logic [15:0]   rx_rdata;
   logic          commit_go;

   assign commit_go = ce_i && rx_state == R_HDR1;
   assign rel_go    = ce_i && wr_go && adr_i == ADR_RX_REL && presented;
   assign rx_raddr  = presented ? hp[AW-1:0] : ld_ptr[AW-1:0];

   pqf_qmem #(.DW(16), .AW(AW)) u_receive_queue (                     // [R02]
      .clk_i   (clk_i),
      .ce_i    (ce_i),
      .we_i    (rx_we),
      .waddr_i (rx_waddr),
      .wdata_i (rx_wdata),
      .raddr_i (rx_raddr),
      .rdata_o (rx_rdata)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_frames <= '0;
      end else if (commit_go && !rel_go) begin
         rx_frames <= rx_frames + 1'b1;
      end else if (rel_go && !commit_go) begin
         rx_frames <= rx_frames - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ld_state      <= L_IDLE;
         presented     <= 1'b0;
         ld_ptr        <= '0;
         hp            <= '0;
         rx_head       <= '0;
         rx_status_reg <= '0;
         rx_len_reg    <= '0;
      end else if (ce_i) begin
         case (ld_state)
            L_IDLE: begin
               if (rel_go) begin
                  rx_head       <= rx_head + HDR_WORDS + PW'((12'(rx_len_reg) + 12'h001) >> 1);
                  presented     <= 1'b0;
                  rx_status_reg <= '0;                                  // [R12]
                  rx_len_reg    <= '0;
               end else if (!presented && rx_frames != '0) begin
                  ld_ptr   <= rx_head;
                  ld_state <= L_W0;
               end else if (presented && rd_go && adr_i == ADR_RX_DATA) begin
                  hp <= hp + 1'b1;
               end
            end
            L_W0: ld_state <= L_L0;
            L_L0: begin
               rx_status_reg <= rx_rdata;                               // [R11]
               ld_ptr        <= ld_ptr + 1'b1;
               ld_state      <= L_W1;
            end
            L_W1: ld_state <= L_L1;
            L_L1: begin
               rx_len_reg <= rx_rdata[LEN_W-1:0];
               hp         <= rx_head + HDR_WORDS;
               presented  <= 1'b1;
               ld_state   <= L_IDLE;
            end
            default: ld_state <= L_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (ce_i) begin
         dat_o <= '0;
         if (rd_go) begin
            case (adr_i)
               ADR_CTRL:    dat_o <= 32'(ctrl_reg);
               ADR_TX_FREE: dat_o <= 32'(tx_free);
               ADR_TX_STAT: dat_o <= 32'(tx_status_reg);
               ADR_RX_STAT: dat_o <= 32'(rx_status_reg);
               ADR_RX_CNT:  dat_o <= 32'(rx_len_reg);
               ADR_RX_DATA: dat_o <= presented ? 32'(rx_rdata) : 32'h0000_0000;
               default:     dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

/* File: tb/pqf_top_monitor.sv */
// Checker on the ports of the packet queue formatter.
// Assumes ce_i held high; bound onto every pqf_top instance.
`timescale 1ns/1ps
module pqf_top_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_valid_o,
   input wire logic        tx_last_o,
   input wire logic        tx_ready_i,
   input wire logic        tx_irq_o,
   input wire logic        rx_valid_i,
   input wire logic        rx_last_i,
   input wire logic        rx_ready_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack held too long");
   ack_delay_a: assert property ($rose(cyc_i && stb_i) |=> !ack_o ##1 ack_o)
      else $error("ack latency wrong");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i, 2))
      else $error("ack without request");
   dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
      else $error("tx byte changed while stalled");
   last_valid_a: assert property (tx_last_o |-> tx_valid_o)
      else $error("last without valid");
   irq_pulse_a: assert property (tx_irq_o |=> !tx_irq_o)
      else $error("irq longer than one cycle");
   irq_cause_a: assert property (tx_irq_o |-> $past(tx_last_o) || $past(tx_last_o, 2))
      else $error("irq not after last byte");
   // Dropped frames keep ready high, so only a kept frame opens the gap
   rx_hdr_gap_a: assert property (rx_valid_i && rx_ready_o && rx_last_i ##1 !rx_ready_o |=>
      (!rx_ready_o)[*2] ##[1:6] rx_ready_o)
      else $error("rx ready gap wrong");
endmodule
bind pqf_top pqf_top_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .dat_o(dat_o), .ack_o(ack_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
   .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .tx_irq_o(tx_irq_o),
   .rx_valid_i(rx_valid_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o));

/* File: tb/pqf_mac_model.sv */
// MAC side model: byte sink for transmit, 20-byte frame source for receive.
// Assumes one clock; slow_i holds transmit ready low on every other cycle.
`timescale 1ns/1ps
module pqf_mac_model (
   input  wire logic       clk_i,
   input  wire logic       slow_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i,
   input  wire logic       tx_last_i,
   output logic            tx_ready_o,
   output logic [7:0]      rx_data_o,
   output logic            rx_valid_o,
   output logic            rx_last_o,
   output logic            rx_crc_err_o,
   output logic            rx_runt_o,
   input  wire logic       rx_ready_i
);
   logic [8:0] got[$];
   logic       ph = 1'b0;
   initial begin
      tx_ready_o = 1'b0;
      {rx_data_o, rx_valid_o, rx_last_o, rx_crc_err_o, rx_runt_o} = 12'h000;
   end
   always @(posedge clk_i) begin
      ph <= ~ph;
      tx_ready_o <= !slow_i || ph;
      if (tx_valid_i && tx_ready_o) got.push_back({tx_last_i, tx_data_i});
   end
   // DA bytes, then type high byte at 12
   task automatic send(input logic [7:0] da, th, input logic crc, runt);
      for (int k = 0; k < 20; k++) begin
         rx_valid_o <= 1'b1;
         rx_data_o <= (k < 6) ? da : (k == 12) ? th : (k == 13) ? 8'h00 : 8'(k);
         rx_last_o <= (k == 19);
         rx_crc_err_o <= crc && k == 19;
         rx_runt_o <= runt && k == 19;
         do @(posedge clk_i); while (rx_ready_i !== 1'b1);
      end
      rx_valid_o <= 1'b0;
      rx_last_o <= 1'b0;
      rx_data_o <= ~rx_data_o;
   endtask
endmodule

/* File: tb/packet_queue_frame_format_test.sv */
// Testbench of the packet queue formatter over Wishbone.
// Assumes pqf_mac_model on the streams and the bound checker.
`timescale 1ns/1ps
module packet_queue_frame_format_test;
   import pqf_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
   logic [7:0]  adr = 8'h00, tx_data, rx_data;
   logic [31:0] dat = 32'h0, q, dat_o;
   logic        ack, tx_valid, tx_last, tx_ready, tx_irq, rx_valid, rx_last, rx_crc, rx_runt;
   logic        rx_ready;
   int          miscompares = 0, n_compared = 0, irqs = 0, i;
   pqf_top i_pqf_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
      .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_last_o(tx_last), .tx_ready_i(tx_ready),
      .tx_irq_o(tx_irq), .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_last_i(rx_last),
      .rx_crc_err_i(rx_crc), .rx_runt_i(rx_runt), .rx_ready_o(rx_ready));
   pqf_mac_model i_pqf_mac_model (.clk_i(clk_i), .slow_i(slow), .tx_data_i(tx_data),
      .tx_valid_i(tx_valid), .tx_last_i(tx_last), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
      .rx_valid_o(rx_valid), .rx_last_o(rx_last), .rx_crc_err_o(rx_crc), .rx_runt_o(rx_runt),
      .rx_ready_i(rx_ready));
   initial forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (tx_irq === 1'b1) irqs++;
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] r);
      int n = 0;
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, 16'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
      r = dat_o;
      if (n >= 20) miscompares++;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask
   task automatic rx_case(input logic [7:0] da, th, ctl, input logic crc, runt,
                          input logic [31:0] st, cnt);
      wb(1'b1, ADR_CTRL, {8'h00, ctl}, q);
      i_pqf_mac_model.send(da, th, crc, runt);
      q = 32'h0;
      for (int k = 0; k < 40 && q[15] !== 1'b1; k++) wb(1'b0, ADR_RX_STAT, 16'h0, q);
      chk("rx_stat", q, st);
      if (st != 0) begin
         wb(1'b0, ADR_RX_CNT, 16'h0, q);
         chk("rx_cnt", q, cnt);
         wb(1'b0, ADR_RX_DATA, 16'h0, q);
         chk("rx_word0", q, {16'h0, da, da});
         wb(1'b1, ADR_RX_REL, 16'h0, q);
         wb(1'b0, ADR_RX_STAT, 16'h0, q);
         chk("rx_empty", q, 32'h0);
      end
   endtask
   task automatic conclude;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      conclude;
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, ADR_TX_FREE, 16'h0, q);
      chk("tx_free", q, 32'h800);
      wb(1'b0, 8'h24, 16'h0, q);
      chk("unmapped", q, 32'h0);
      // Odd count under stalls: final high byte must be dropped
      slow <= 1'b1;
      wb(1'b1, ADR_TX_DATA, 16'h802A, q);
      wb(1'b1, ADR_TX_DATA, 16'h000D, q);
      for (i = 0; i < 14; i += 2) wb(1'b1, ADR_TX_DATA, 16'hA1A0 + 16'(i) * 16'h0101, q);
      wb(1'b1, ADR_TX_DATA, 16'h0005, q);
      wb(1'b1, ADR_TX_DATA, 16'h0002, q);
      wb(1'b1, ADR_TX_DATA, 16'h5A5B, q);
      for (i = 0; i < 400 && i_pqf_mac_model.got.size() < 15; i++) @(posedge clk_i);
      repeat (10) @(posedge clk_i);
      chk("tx_count", i_pqf_mac_model.got.size(), 15);
      for (i = 0; i < 13; i++)
         chk("tx_byte", i_pqf_mac_model.got[i], {i == 12, 8'(160 + i)});
      chk("tx_irq", irqs, 1);
      wb(1'b0, ADR_TX_STAT, 16'h0, q);
      chk("tx_tag", q[8:0], 9'h005);
      $display("transmit test done");
      rx_case(8'hFF, 8'h08, 8'h00, 1'b0, 1'b0, 32'h80C8, 32'd20);
      rx_case(8'h02, 8'h00, 8'h00, 1'b1, 1'b0, 32'h0, 32'h0);
      rx_case(8'h02, 8'h00, 8'h00, 1'b0, 1'b1, 32'h0, 32'h0);
      rx_case(8'h02, 8'h00, 8'h01, 1'b1, 1'b0, 32'h8021, 32'd20);
      rx_case(8'h01, 8'h00, 8'h03, 1'b0, 1'b1, 32'h8042, 32'd16);
      $display("receive test done");
      conclude;
   end
endmodule
